/* logic/frn_ratio_ctrl.sv */
// digital ratio control of a hybrid fractional-n clock synthesizer
// Function
// - the synthesizer output is the timing reference times the ratio n given to the modulator.
// - the modulator varies the integer divide value so its carry density gives the fraction of n.
// - in hybrid mode the loop measures output to reference-input ratio, compares it with the target, and makes n.
// - the loop starts with a wide bandwidth to lock fast and narrows it once locked.
// - n comes from the static stored ratio or from the dynamic loop ratio.
// - the source is chosen automatically by reference-input presence or manually by a control bit.
// - the target ratio against the reference input is turned into a ratio against the divided clock.
// - with skipping on, the loop stays locked through reference gaps of up to 20 ms.
// - the input skip enable bit turns skipping on when set and off when clear.
// - after the reference input stops cleanly, output runs 2^23 divided cycles before unlock is declared.
// - without skipping, a returning input unlocks the loop only while it reacquires, output gated by its setting.
`timescale 1ns/1ps
module frn_ratio_ctrl #(
   parameter int TIMEOUT_TICKS = frn_pkg::TIMEOUT_TICKS_DFLT,
   parameter int SKIP_CYCLES = frn_pkg::SKIP_CYCLES_DFLT,
   parameter int LOCK_COUNT = frn_pkg::LOCK_COUNT_DFLT
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [frn_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [frn_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [frn_pkg::DATA_W-1:0] bus_rdata,
   input wire logic freq_ref_in,
   output logic divided_reference_clock,
   output logic [frn_pkg::INT_W:0] divide_value,
   output logic divide_strobe,
   output logic clock_out_enable,
   output logic pll_locked
);
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      div_mask = 3'(({3'h0, 1'b1} << sel) - 4'h1);
   endfunction

   function automatic logic [5:0] msb_index(input logic [frn_pkg::TICK_W-1:0] v);
      msb_index = 6'h00;
      for (int i = 0; i < frn_pkg::TICK_W; i++) begin
         if (v[i]) begin
            msb_index = 6'(i);
         end
      end
   endfunction

   // software registers
   frn_pkg::frn_ctrl_t ctrl, next_ctrl;
   frn_pkg::frn_ratio_t static_ratio, next_static_ratio;
   frn_pkg::frn_ratio_t desired_ratio, next_desired_ratio;
   logic [frn_pkg::DATA_W-1:0] next_rdata;
   // loop state
   frn_pkg::frn_loop_t state, next_state;
   frn_pkg::frn_ratio_t loop_n, next_loop_n;
   frn_pkg::frn_ratio_t n_active, next_n_active;
   logic [2:0] div_cnt, next_div_cnt;
   logic sys_tick, next_sys_tick;
   logic ref_d;
   logic [frn_pkg::PH_W-1:0] phase_acc, next_phase_acc;
   logic [frn_pkg::TICK_W-1:0] tick_gap, next_tick_gap;
   logic [31:0] gap_cnt, next_gap_cnt;
   logic [7:0] lock_cnt, next_lock_cnt;
   logic next_locked, next_out_en;
   // combinational helpers
   logic ref_rise, use_dynamic, long_gap, timeout_hit;
   logic signed [frn_pkg::PH_W:0] err, delta;
   logic [frn_pkg::PH_W:0] desired_ext, abs_err;
   logic [5:0] bw_shift;

   // register file
   always_comb begin
      next_ctrl = ctrl;
      next_static_ratio = static_ratio;
      next_desired_ratio = desired_ratio;
      next_rdata = '0;
      if (bus_wr) begin
         case (bus_addr)
            frn_pkg::ADDR_CTRL: next_ctrl = bus_wdata[frn_pkg::CTRL_W-1:0];
            frn_pkg::ADDR_STATIC_RATIO: next_static_ratio = bus_wdata;
            frn_pkg::ADDR_DESIRED_RATIO: next_desired_ratio = bus_wdata;
            default: ;
         endcase
      end
      if (bus_rd) begin
         case (bus_addr)
            frn_pkg::ADDR_CTRL: next_rdata = {{(frn_pkg::DATA_W-frn_pkg::CTRL_W){1'b0}}, ctrl};
            frn_pkg::ADDR_STATIC_RATIO: next_rdata = static_ratio;
            frn_pkg::ADDR_DESIRED_RATIO: next_rdata = desired_ratio;
            frn_pkg::ADDR_STATUS: begin
               next_rdata[frn_pkg::ST_LOCKED] = pll_locked;
               next_rdata[frn_pkg::ST_REF_PRESENT] = state != frn_pkg::LOOP_IDLE;
               next_rdata[frn_pkg::ST_DYNAMIC] = use_dynamic;
               next_rdata[frn_pkg::ST_ACQUIRE] = state == frn_pkg::LOOP_ACQUIRE;
            end
            frn_pkg::ADDR_LOOP_RATIO: next_rdata = loop_n;
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= frn_pkg::CTRL_RST;
         static_ratio <= frn_pkg::RATIO_RST;
         desired_ratio <= frn_pkg::RATIO_RST;
         bus_rdata <= '0;
      end else begin
         ctrl <= next_ctrl;
         static_ratio <= next_static_ratio;
         desired_ratio <= next_desired_ratio;
         bus_rdata <= next_rdata;
      end
   end

   // divided reference tick, source selection and digital loop
   always_comb begin
      ref_rise = freq_ref_in & ~ref_d;
      next_div_cnt = div_cnt + 3'h1;
      next_sys_tick = (div_cnt & div_mask(ctrl.ref_divider_select)) == div_mask(ctrl.ref_divider_select);
      use_dynamic = ctrl.auto_source ? (state != frn_pkg::LOOP_IDLE) : ctrl.manual_dynamic;
      next_n_active = use_dynamic ? loop_n : static_ratio;
      desired_ext = {{(frn_pkg::PH_W+1-frn_pkg::RATIO_W){1'b0}}, desired_ratio};
      // measured output cycles over one reference period against the target
      err = $signed(desired_ext) - $signed({1'b0, phase_acc});
      abs_err = err[frn_pkg::PH_W] ? 57'(-err) : 57'(err);
      long_gap = {1'b0, phase_acc} > desired_ext + (desired_ext >> 1);
      bw_shift = (state == frn_pkg::LOOP_LOCKED) ? frn_pkg::BW_NARROW_SHIFT : frn_pkg::BW_WIDE_SHIFT;
      // dividing by the period length in divided ticks rescales to the divided clock
      delta = err >>> (msb_index(tick_gap | 24'h000001) + bw_shift);
      timeout_hit = sys_tick && (32'(tick_gap) == 32'(TIMEOUT_TICKS - 1));
      next_state = state;
      next_loop_n = loop_n;
      next_lock_cnt = lock_cnt;
      next_phase_acc = sys_tick ? phase_acc + {{(frn_pkg::PH_W-frn_pkg::RATIO_W){1'b0}}, n_active} : phase_acc;
      next_tick_gap = (sys_tick && tick_gap != '1) ? tick_gap + 24'h000001 : tick_gap;
      next_gap_cnt = (gap_cnt == 32'(SKIP_CYCLES + 1)) ? gap_cnt : gap_cnt + 32'h1;
      if (ref_rise) begin
         // a tick in the edge cycle opens the next period, so no tick drops out of the measurement
         next_phase_acc = sys_tick ? {{(frn_pkg::PH_W-frn_pkg::RATIO_W){1'b0}}, n_active} : '0;
         next_tick_gap = '0;
         next_gap_cnt = '0;
         case (state)
            frn_pkg::LOOP_IDLE: begin
               next_state = frn_pkg::LOOP_ACQUIRE;
               next_lock_cnt = '0;
            end
            frn_pkg::LOOP_ACQUIRE, frn_pkg::LOOP_LOCKED: begin
               if (long_gap) begin
                  if (ctrl.input_skip_enable && state == frn_pkg::LOOP_LOCKED
                      && gap_cnt <= 32'(SKIP_CYCLES)) begin
                     next_state = frn_pkg::LOOP_LOCKED;
                  end else begin
                     next_state = frn_pkg::LOOP_ACQUIRE;
                     next_lock_cnt = '0;
                  end
               end else begin
                  next_loop_n = loop_n + delta[frn_pkg::RATIO_W-1:0];
                  if (abs_err > frn_pkg::LOCK_TOL) begin
                     next_lock_cnt = '0;
                  end else if (lock_cnt != 8'(LOCK_COUNT)) begin
                     next_lock_cnt = lock_cnt + 8'h01;
                  end
                  if (state == frn_pkg::LOOP_ACQUIRE && abs_err <= frn_pkg::LOCK_TOL
                      && lock_cnt == 8'(LOCK_COUNT - 1)) begin
                     next_state = frn_pkg::LOOP_LOCKED;
                  end
               end
            end
            default: next_state = frn_pkg::LOOP_IDLE;
         endcase
      end else if (timeout_hit && state != frn_pkg::LOOP_IDLE) begin
         next_state = frn_pkg::LOOP_IDLE;
         next_lock_cnt = '0;
      end
      // plain synthesizer mode is locked to the timing reference
      next_locked = use_dynamic ? (state == frn_pkg::LOOP_LOCKED) : 1'b1;
      next_out_en = next_locked | ctrl.output_on_unlock;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= frn_pkg::LOOP_IDLE;
         loop_n <= frn_pkg::RATIO_RST;
         n_active <= frn_pkg::RATIO_RST;
         div_cnt <= '0;
         sys_tick <= 1'b0;
         ref_d <= 1'b0;
         phase_acc <= '0;
         tick_gap <= '0;
         gap_cnt <= '0;
         lock_cnt <= '0;
         pll_locked <= 1'b0;
         clock_out_enable <= 1'b0;
      end else begin
         state <= next_state;
         loop_n <= next_loop_n;
         n_active <= next_n_active;
         div_cnt <= next_div_cnt;
         sys_tick <= next_sys_tick;
         ref_d <= freq_ref_in;
         phase_acc <= next_phase_acc;
         tick_gap <= next_tick_gap;
         gap_cnt <= next_gap_cnt;
         lock_cnt <= next_lock_cnt;
         pll_locked <= next_locked;
         clock_out_enable <= next_out_en;
      end
   end

   assign divided_reference_clock = sys_tick;

   // n drives the modulator once per divided tick
   frn_dsm #(.INT_W(frn_pkg::INT_W), .FRAC_W(frn_pkg::FRAC_W)) u_dsm (
      .mclk(mclk),
      .resetn(resetn),
      .en(sys_tick),
      .ratio(n_active),
      .div_value(divide_value),
      .div_strobe(divide_strobe)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_divide_tracks_n: assert property (sys_tick ##1 divide_strobe |->
      divide_value - {1'b0, $past(n_active.int_part)} <= 13'h0001)
      else $error("divide value strays from the integer part of n");
   a_idle_to_acquire: assert property (state == frn_pkg::LOOP_IDLE && ref_rise |=>
      state == frn_pkg::LOOP_ACQUIRE) else $error("first reference edge did not start acquisition");
   a_bandwidth_by_state: assert property (state == frn_pkg::LOOP_ACQUIRE ##1 state == frn_pkg::LOOP_LOCKED
      |-> $past(bw_shift) < bw_shift) else $error("bandwidth did not narrow at lock");
   a_source_follows_n: assert property (use_dynamic ##1 $stable(loop_n) |-> n_active == loop_n)
      else $error("dynamic mode does not feed loop ratio");
   a_manual_source: assert property (!ctrl.auto_source |-> use_dynamic == ctrl.manual_dynamic)
      else $error("manual source selection ignored");
   a_auto_source: assert property (ctrl.auto_source && state == frn_pkg::LOOP_IDLE ##1
      ctrl.auto_source && state == frn_pkg::LOOP_IDLE |-> n_active == $past(static_ratio))
      else $error("static ratio not used without reference input");
   a_zero_error_hold: assert property (ref_rise && state != frn_pkg::LOOP_IDLE && !long_gap
      && err == '0 |=> loop_n == $past(loop_n)) else $error("loop ratio moved with zero error");
   a_skip_holds_lock: assert property (ref_rise && long_gap && state == frn_pkg::LOOP_LOCKED
      && ctrl.input_skip_enable && gap_cnt <= 32'(SKIP_CYCLES) |=> state == frn_pkg::LOOP_LOCKED)
      else $error("skip mode lost lock inside the window");
   a_noskip_reacquire: assert property (ref_rise && long_gap && !ctrl.input_skip_enable
      && state != frn_pkg::LOOP_IDLE |=> state == frn_pkg::LOOP_ACQUIRE)
      else $error("returning input did not force reacquisition");
   a_timeout_unlock: assert property (timeout_hit && !ref_rise && state != frn_pkg::LOOP_IDLE |=>
      state == frn_pkg::LOOP_IDLE) else $error("timeout did not declare unlock");
   a_output_gate: assert property (##1 pll_locked == 1'b0 && !$past(ctrl.output_on_unlock)
      |-> !clock_out_enable) else $error("output enabled while unlocked");

   c_lock_reached: cover property (state == frn_pkg::LOOP_ACQUIRE ##1 state == frn_pkg::LOOP_LOCKED);
   c_skip_held: cover property (ref_rise && long_gap && state == frn_pkg::LOOP_LOCKED ##1
      state == frn_pkg::LOOP_LOCKED);
   c_timeout: cover property (state == frn_pkg::LOOP_LOCKED ##1 state == frn_pkg::LOOP_IDLE);
   c_dynamic_used: cover property (use_dynamic && pll_locked);
endmodule // frn_ratio_ctrl

/* shared/frn_pkg.sv */
// shared constants and types for the fractional-n ratio control block
package frn_pkg;
   localparam int INT_W = 12;
   localparam int FRAC_W = 20;
   localparam int RATIO_W = INT_W + FRAC_W;
   localparam int PH_W = 56;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int TICK_W = 24;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STATIC_RATIO = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_DESIRED_RATIO = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_LOOP_RATIO = 4'h4;

   // ctrl word layout, low bits of the ctrl register
   typedef struct packed {
      logic manual_dynamic;
      logic auto_source;
      logic output_on_unlock;
      logic input_skip_enable;
      logic [1:0] ref_divider_select;
   } frn_ctrl_t;

   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h10;

   typedef struct packed {
      logic [INT_W-1:0] int_part;
      logic [FRAC_W-1:0] frac_part;
   } frn_ratio_t;

   localparam logic [RATIO_W-1:0] RATIO_RST = 32'h0010_0000;

   typedef enum logic [1:0] {LOOP_IDLE, LOOP_ACQUIRE, LOOP_LOCKED} frn_loop_t;

   // status word bit positions
   localparam int ST_LOCKED = 0;
   localparam int ST_REF_PRESENT = 1;
   localparam int ST_DYNAMIC = 2;
   localparam int ST_ACQUIRE = 3;

   // timing
   localparam longint CLK_HZ = 20_000_000;
   localparam longint SKIP_MS = 20;
   localparam int SKIP_CYCLES_DFLT = int'(SKIP_MS * CLK_HZ / 1000);
   localparam int TIMEOUT_LOG2 = 23;
   localparam int TIMEOUT_TICKS_DFLT = 2 ** TIMEOUT_LOG2;

   // loop gain as extra right shift on top of the period normalisation
   localparam logic [5:0] BW_WIDE_SHIFT = 6'h01;
   localparam logic [5:0] BW_NARROW_SHIFT = 6'h05;
   localparam logic [PH_W:0] LOCK_TOL = 57'h000_0000_0000_4000;
   localparam int LOCK_COUNT_DFLT = 8;
endpackage

/* logic/frn_dsm.sv */
// first-order delta-sigma modulator of the loop divide value
`timescale 1ns/1ps
module frn_dsm #(
   parameter int INT_W = 12,
   parameter int FRAC_W = 20
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic en,
   input wire logic [INT_W+FRAC_W-1:0] ratio,
   output logic [INT_W:0] div_value,
   output logic div_strobe
);
   logic [FRAC_W-1:0] acc;
   logic [FRAC_W-1:0] next_acc;
   logic [INT_W:0] next_div_value;
   logic next_div_strobe;
   logic [FRAC_W:0] sum;

   always_comb begin
      // carry density equals the fraction
      sum = {1'b0, acc} + {1'b0, ratio[FRAC_W-1:0]};
      next_acc = acc;
      next_div_value = div_value;
      next_div_strobe = en;
      if (en) begin
         next_acc = sum[FRAC_W-1:0];
         next_div_value = {1'b0, ratio[INT_W+FRAC_W-1:FRAC_W]} + {{INT_W{1'b0}}, sum[FRAC_W]};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acc <= '0;
         div_value <= '0;
         div_strobe <= 1'b0;
      end else begin
         acc <= next_acc;
         div_value <= next_div_value;
         div_strobe <= next_div_strobe;
      end
   end

   a_dsm_integer_only: assert property (@(posedge mclk) disable iff (!resetn)
      en && ratio[FRAC_W-1:0] == '0 && acc == '0 |=> div_value == {1'b0, $past(ratio[INT_W+FRAC_W-1:FRAC_W])})
      else $error("modulator added a carry with zero fraction");
endmodule // frn_dsm

/* test/frn_ref_source.sv */
// behavioural frequency reference input source for the ratio control bench
`timescale 1ns/1ps
module frn_ref_source (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [9:0] period,
   output logic freq_ref_in
);
   logic [9:0] cnt;

   // stopping restarts the period so a return always begins with a clean rising edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 10'h000;
      end else if (!run || cnt == period - 10'h001) begin
         cnt <= 10'h000;
      end else begin
         cnt <= cnt + 10'h001;
      end
   end

   // high for the first half of each period, held low while stopped
   assign freq_ref_in = run && (cnt < (period >> 1));
endmodule // frn_ref_source

/* test/frn_ratio_ctrl_tb.sv */
// self-checking bench for the fractional-n ratio control block
`timescale 1ns/1ps
module frn_ratio_ctrl_tb;
   typedef struct {
      logic wr;
      logic [3:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } frn_row_t;

   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] bus_addr = 4'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] bus_rdata;
   logic freq_ref_in, divided_reference_clock, divide_strobe, clock_out_enable, pll_locked;
   logic [12:0] divide_value;
   logic ref_run = 1'b0;
   logic [31:0] rd;
   int n_errors = 0;
   int n_compared = 0;
   int cnt, lo_l, lo_e;
   frn_row_t rows [11];

   always #25 mclk = ~mclk;

   // short counts keep the run small: one reference period of 256 mclk fits inside both windows
   frn_ratio_ctrl #(.TIMEOUT_TICKS(1024), .SKIP_CYCLES(800), .LOCK_COUNT(2)) u_dut (
      .mclk(mclk),
      .resetn(resetn),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_rdata(bus_rdata),
      .freq_ref_in(freq_ref_in),
      .divided_reference_clock(divided_reference_clock),
      .divide_value(divide_value),
      .divide_strobe(divide_strobe),
      .clock_out_enable(clock_out_enable),
      .pll_locked(pll_locked)
   );

   frn_ref_source u_src (.mclk(mclk), .resetn(resetn), .run(ref_run), .period(10'h100), .freq_ref_in(freq_ref_in));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask

   task automatic print_verdict;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // counts the cycles in which lock or the output enable were low
   task automatic watch(input int n);
      lo_l = 0;
      lo_e = 0;
      repeat (n) begin
         tick(1);
         lo_l += (pll_locked !== 1'b1);
         lo_e += (clock_out_enable !== 1'b1);
      end
   endtask

   task automatic wait_lock;
      cnt = 0;
      while (pll_locked !== 1'b1 && cnt < 20000) begin
         tick(1);
         cnt++;
      end
      if (cnt == 20000) begin
         n_errors++;
         print_verdict();
      end
   endtask

   task automatic gap(input int n);
      @(posedge mclk);
      ref_run <= 1'b0;
      tick(n);
      @(posedge mclk);
      ref_run <= 1'b1;
   endtask

   initial begin
      rows = '{'{1'b0, 4'h0, 32'h0, 32'h10}, '{1'b0, 4'h1, 32'h0, 32'h0010_0000},
               '{1'b0, 4'h2, 32'h0, 32'h0010_0000}, '{1'b0, 4'h3, 32'h0, 32'h1},
               '{1'b0, 4'h5, 32'h0, 32'h0}, '{1'b1, 4'h5, 32'hffff_ffff, 32'h0},
               '{1'b1, 4'h0, 32'hffff_ffd3, 32'h13}, '{1'b1, 4'h1, 32'h0034_0000, 32'h0034_0000},
               '{1'b1, 4'h2, 32'h2000_0000, 32'h2000_0000}, '{1'b1, 4'h3, 32'hffff_ffff, 32'h1},
               '{1'b1, 4'h0, 32'h10, 32'h10}};
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            bus_write(rows[i].addr, rows[i].wdata);
         end
         bus_read(rows[i].addr, rd);
         check(rd, rows[i].exp);
      end
      for (int s = 0; s < 4; s++) begin
         bus_write(4'h0, 32'h10 | s);
         tick(4);
         cnt = 0;
         repeat (64) begin
            tick(1);
            cnt += divided_reference_clock;
         end
         check(cnt, 64 >> s);
      end
      // static ratio 3.25: sixteen divide values sum to 52
      bus_write(4'h0, 32'h10);
      tick(8);
      cnt = 0;
      repeat (16) begin
         tick(1);
         cnt += divide_strobe ? int'(divide_value) : 1000;
      end
      check(cnt, 52);
      // desired 512 output cycles per 256-cycle reference period gives 2.0 per tick
      @(posedge mclk);
      ref_run <= 1'b1;
      watch(600);
      check(32'(lo_l > 0), 32'h1);
      wait_lock();
      bus_read(4'h4, rd);
      check(32'(rd - 32'h0020_0000 + 32'h4000 <= 32'h8000), 32'h1);
      bus_read(4'h3, rd);
      check(rd, 32'h7);
      bus_write(4'h0, 32'h00);
      tick(4);
      bus_read(4'h3, rd);
      check(rd & 32'h5, 32'h1);
      bus_write(4'h0, 32'h20);
      tick(4);
      bus_read(4'h3, rd);
      check(rd & 32'h4, 32'h4);
      bus_write(4'h0, 32'h14);
      // 500 idle cycles always exceed the missed-pulse threshold yet stay inside the skip window
      gap(500);
      watch(1000);
      check(lo_l, 0);
      bus_write(4'h0, 32'h10);
      gap(500);
      watch(40);
      check(32'(lo_l > 0 && lo_e > 0), 32'h1);
      wait_lock();
      bus_write(4'h0, 32'h18);
      gap(500);
      watch(40);
      check(32'(lo_l > 0 && lo_e == 0), 32'h1);
      wait_lock();
      bus_write(4'h0, 32'h10);
      @(posedge mclk);
      ref_run <= 1'b0;
      watch(600);
      bus_read(4'h3, rd);
      check((rd & 32'h5) | 32'(lo_l + lo_e), 32'h5);
      tick(600);
      bus_read(4'h3, rd);
      check(rd & 32'h7, 32'h1);
      // mid-run reset: outputs drop at once and the registers return to their reset values
      bus_write(4'h0, 32'h3b);
      @(posedge mclk);
      resetn <= 1'b0;
      tick(2);
      check(32'({divide_value, divided_reference_clock, divide_strobe, clock_out_enable, pll_locked}), 32'h0);
      @(posedge mclk);
      resetn <= 1'b1;
      bus_read(4'h0, rd);
      check(rd, 32'h10);
      bus_read(4'h3, rd);
      check(rd, 32'h1);
      print_verdict();
   end
endmodule // frn_ratio_ctrl_tb
